// ==== mcs_pkg.sv ====
// Package: constants for the monitor channel and status flag block
// Assumes one 100 MHz clock and a synchronous active-high reset
package mcs_pkg;
  localparam int NUM_CH = 6;
  localparam int WORD_W = 16;
  localparam int DATA_W = 32;
  localparam int CODE_W = 8;
  localparam int ERR_W  = 8;
  // Target address encodings
  localparam logic [7:0] ADDR_LAST_SLAVE = 8'h0b;
  localparam logic [7:0] ADDR_SELF       = 8'h80;
  // Communication error codes
  localparam logic [ERR_W-1:0] ERR_NONE    = 8'h00;
  localparam logic [ERR_W-1:0] ERR_LINK    = 8'h84;
  localparam logic [ERR_W-1:0] ERR_TIMEOUT = 8'h85;
  // Reset values
  localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;
  typedef enum logic [1:0] {
    MCS_CMD_IDLE = 2'b00,
    MCS_CMD_BUSY = 2'b01,
    MCS_CMD_DONE = 2'b10,
    MCS_CMD_FAIL = 2'b11
  } mcs_cmd_state_t;
endpackage

// ==== mcs_monitor_channel.sv ====
// One monitor channel: request edge capture, scan refresh, error handling
// Assumes request, scan results and strobes are synchronous to ref_clk
`timescale 1ns/1ps
module mcs_monitor_channel (
  input  wire logic                       ref_clk,
  input  wire logic                       rst,
  input  wire logic                       monitor_request,
  input  wire logic [mcs_pkg::WORD_W-1:0] monitor_code_word,
  input  wire logic [mcs_pkg::WORD_W-1:0] monitor_target_word,
  input  wire logic                       scan_done,
  input  wire logic                       scan_ok,
  input  wire logic [mcs_pkg::DATA_W-1:0] scan_data,
  output logic [mcs_pkg::WORD_W-1:0]      code_reg,
  output logic [mcs_pkg::WORD_W-1:0]      target_reg,
  output logic                            monitor_active,
  output logic                            error_reg,
  output logic                            start_pulse,
  output logic                            ok_pulse,
  output logic [mcs_pkg::WORD_W-1:0]      monitor_data_low,
  output logic [mcs_pkg::WORD_W-1:0]      monitor_data_high
);
  import mcs_pkg::*;

  logic req_d_reg;
  logic rise;
  logic fall;

  assign rise = monitor_request & ~req_d_reg;
  assign fall = ~monitor_request & req_d_reg;

  // ---------------------------------------------------------------
  // Request edge
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      req_d_reg   <= 1'b0;
      start_pulse <= 1'b0;
    end else begin
      req_d_reg   <= monitor_request;
      start_pulse <= rise;
    end
  end

  // ---------------------------------------------------------------
  // Code and address capture
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      code_reg   <= WORD_RST;
      target_reg <= WORD_RST;
    end else if (rise) begin
      code_reg   <= monitor_code_word;
      target_reg <= monitor_target_word;
    end
  end

  // ---------------------------------------------------------------
  // Active flag, error and data
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      monitor_active <= 1'b0;
      ok_pulse       <= 1'b0;
    end else begin
      ok_pulse <= 1'b0;
      if (!monitor_request) begin
        monitor_active <= 1'b0;
      end else if (rise) begin
        monitor_active <= 1'b1;
      end else if (req_d_reg && scan_done) begin
        monitor_active <= scan_ok;
        ok_pulse       <= scan_ok;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      error_reg <= 1'b0;
    end else if (req_d_reg && monitor_request && scan_done && !scan_ok) begin
      error_reg <= 1'b1;
    end else if (fall) begin
      error_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      monitor_data_low  <= WORD_RST;
      monitor_data_high <= WORD_RST;
    end else if (req_d_reg && monitor_request && scan_done) begin
      if (scan_ok) begin
        monitor_data_low  <= scan_data[WORD_W-1:0];
        monitor_data_high <= scan_data[DATA_W-1:WORD_W];
      end else begin
        monitor_data_low  <= WORD_RST;
        monitor_data_high <= WORD_RST;
      end
    end
  end
  // Data held once request drops: no update path without request
endmodule

// ==== mcs_status_flags.sv ====
// Top: status flags, command handshake and six monitor channels
// Assumes the master words and bits and the RS-485 engine results are
// synchronous to ref_clk; the engine reports each result with a done strobe
`timescale 1ns/1ps
module mcs_status_flags (
  input  wire logic                                       ref_clk,
  input  wire logic                                       rst,
  // Master side
  input  wire logic [mcs_pkg::NUM_CH-1:0]                 monitor_request,
  input  wire logic [mcs_pkg::NUM_CH*mcs_pkg::WORD_W-1:0] monitor_code_word,
  input  wire logic [mcs_pkg::NUM_CH*mcs_pkg::WORD_W-1:0] monitor_target_word,
  input  wire logic                                       command_request,
  input  wire logic                                       alarm_clear,
  // Device internals
  input  wire logic                                       cmd_done,
  input  wire logic                                       cmd_ok,
  input  wire logic [mcs_pkg::NUM_CH-1:0]                 scan_done,
  input  wire logic [mcs_pkg::NUM_CH-1:0]                 scan_ok,
  input  wire logic [mcs_pkg::NUM_CH*mcs_pkg::DATA_W-1:0] scan_data,
  input  wire logic [mcs_pkg::ERR_W-1:0]                  link_err_code,
  input  wire logic                                       link_err_valid,
  input  wire logic                                       protect_trip,
  input  wire logic                                       warning_cause,
  input  wire logic                                       fieldbus_link_ok,
  // Reply side
  output logic                                            command_busy,
  output logic                                            command_done,
  output logic                                            request_error,
  output logic                                            serial_link_ok,
  output logic                                            alarm_flag,
  output logic                                            warning_flag,
  output logic                                            station_ready,
  output logic [mcs_pkg::NUM_CH-1:0]                      monitor_active,
  output logic [mcs_pkg::NUM_CH*mcs_pkg::WORD_W-1:0]      monitor_data_low,
  output logic [mcs_pkg::NUM_CH*mcs_pkg::WORD_W-1:0]      monitor_data_high,
  output logic [mcs_pkg::NUM_CH*mcs_pkg::WORD_W-1:0]      monitor_code_reg,
  output logic [mcs_pkg::NUM_CH*mcs_pkg::WORD_W-1:0]      monitor_target_reg,
  output logic [mcs_pkg::NUM_CH-1:0]                      monitor_start,
  output logic                                            command_start,
  output logic [mcs_pkg::ERR_W-1:0]                       comm_err_code_reg
);
  import mcs_pkg::*;

  mcs_cmd_state_t     cmd_state_reg;
  mcs_cmd_state_t     cmd_state_next;
  logic               cmd_req_d_reg;
  logic               cmd_rise;
  logic               alarm_clear_d_reg;
  logic [NUM_CH-1:0]  ch_error;
  logic [NUM_CH-1:0]  ch_ok;
  logic [NUM_CH-1:0]  ch_fail_now;
  logic [NUM_CH-1:0]  mon_req_d_reg;

  assign cmd_rise = command_request & ~cmd_req_d_reg;

  // ---------------------------------------------------------------
  // Monitor channels
  // ---------------------------------------------------------------
  genvar k;
  generate
    for (k = 0; k < NUM_CH; k++) begin : g_ch
      mcs_monitor_channel u_ch (
        .ref_clk             (ref_clk),
        .rst                 (rst),
        .monitor_request     (monitor_request[k]),
        .monitor_code_word   (monitor_code_word[k*WORD_W +: WORD_W]),
        .monitor_target_word (monitor_target_word[k*WORD_W +: WORD_W]),
        .scan_done           (scan_done[k]),
        .scan_ok             (scan_ok[k]),
        .scan_data           (scan_data[k*DATA_W +: DATA_W]),
        .code_reg            (monitor_code_reg[k*WORD_W +: WORD_W]),
        .target_reg          (monitor_target_reg[k*WORD_W +: WORD_W]),
        .monitor_active      (monitor_active[k]),
        .error_reg           (ch_error[k]),
        .start_pulse         (monitor_start[k]),
        .ok_pulse            (ch_ok[k]),
        .monitor_data_low    (monitor_data_low[k*WORD_W +: WORD_W]),
        .monitor_data_high   (monitor_data_high[k*WORD_W +: WORD_W])
      );
      assign ch_fail_now[k] = scan_done[k] & ~scan_ok[k] & monitor_request[k] & mon_req_d_reg[k];
    end
  endgenerate

  // Delayed requests, so a result in the rise cycle is ignored
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mon_req_d_reg <= '0;
    end else begin
      mon_req_d_reg <= monitor_request;
    end
  end

  // ---------------------------------------------------------------
  // Command handshake
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cmd_req_d_reg <= 1'b0;
      command_start <= 1'b0;
    end else begin
      cmd_req_d_reg <= command_request;
      command_start <= cmd_rise;
    end
  end

  always_comb begin
    cmd_state_next = cmd_state_reg;
    case (cmd_state_reg)
      MCS_CMD_IDLE: begin
        if (cmd_rise) begin
          cmd_state_next = MCS_CMD_BUSY;
        end
      end
      MCS_CMD_BUSY: begin
        if (cmd_done) begin
          cmd_state_next = cmd_ok ? MCS_CMD_DONE : MCS_CMD_FAIL;
        end
      end
      MCS_CMD_DONE: begin
        if (!command_request) begin
          cmd_state_next = MCS_CMD_IDLE;
        end
      end
      MCS_CMD_FAIL: begin
        if (!command_request) begin
          cmd_state_next = MCS_CMD_IDLE;
        end
      end
      default: begin
        cmd_state_next = MCS_CMD_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cmd_state_reg <= MCS_CMD_IDLE;
    end else begin
      cmd_state_reg <= cmd_state_next;
    end
  end

  // ---------------------------------------------------------------
  // Command flags
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      command_busy <= 1'b0;
      command_done <= 1'b0;
    end else begin
      command_busy <= (cmd_state_next == MCS_CMD_BUSY);
      command_done <= (cmd_state_next == MCS_CMD_DONE);
    end
  end

  // ---------------------------------------------------------------
  // Request error
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      request_error <= 1'b0;
    end else begin
      request_error <= (cmd_state_next == MCS_CMD_FAIL) | (|(monitor_request & (ch_error | ch_fail_now)));
    end
  end

  // ---------------------------------------------------------------
  // Communication error code
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      comm_err_code_reg <= ERR_NONE;
    end else if (link_err_valid) begin
      comm_err_code_reg <= link_err_code;
    end else if ((|ch_ok) || (cmd_state_reg == MCS_CMD_BUSY && cmd_done && cmd_ok)) begin
      comm_err_code_reg <= ERR_NONE;
    end
  end

  // ---------------------------------------------------------------
  // Link, alarm, warning, ready
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      serial_link_ok <= 1'b0;
    end else if (link_err_valid) begin
      serial_link_ok <= 1'b0;
    end else if ((|(scan_done & scan_ok)) || (cmd_done && cmd_ok)) begin
      serial_link_ok <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      alarm_clear_d_reg <= 1'b0;
      alarm_flag        <= 1'b0;
    end else begin
      alarm_clear_d_reg <= alarm_clear;
      if (protect_trip) begin
        alarm_flag <= 1'b1;
      end else if (alarm_clear_d_reg && !alarm_clear) begin
        alarm_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      warning_flag  <= 1'b0;
      station_ready <= 1'b0;
    end else begin
      warning_flag  <= warning_cause;
      station_ready <= fieldbus_link_ok;
    end
  end
endmodule

// ==== mcs_status_flags_monitor.sv ====
// Checker for the status flag block, attached to its top ports
// Assumes one clock domain; channel 0 stands for all monitor channels
`timescale 1ns/1ps
module mcs_status_flags_monitor (
  input wire logic                       ref_clk,
  input wire logic                       rst,
  input wire logic [mcs_pkg::NUM_CH-1:0] monitor_request,
  input wire logic                       command_request,
  input wire logic                       alarm_clear,
  input wire logic                       cmd_done,
  input wire logic                       cmd_ok,
  input wire logic [mcs_pkg::NUM_CH-1:0] scan_done,
  input wire logic [mcs_pkg::NUM_CH-1:0] scan_ok,
  input wire logic                       protect_trip,
  input wire logic                       warning_cause,
  input wire logic                       fieldbus_link_ok,
  input wire logic                       command_busy,
  input wire logic                       command_done,
  input wire logic                       request_error,
  input wire logic                       alarm_flag,
  input wire logic                       warning_flag,
  input wire logic                       station_ready,
  input wire logic [mcs_pkg::NUM_CH-1:0] monitor_active,
  input wire logic [mcs_pkg::NUM_CH-1:0] monitor_start,
  input wire logic                       command_start
);
  import mcs_pkg::*;
  // --------------------------------
  // Sequences and properties
  // --------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_cmd_rise;
    !command_request ##1 (command_request && !command_busy && !command_done && !request_error);
  endsequence
  sequence s_cmd_ok;
    command_busy && cmd_done && cmd_ok;
  endsequence
  sequence s_cmd_bad;
    command_busy && cmd_done && !cmd_ok;
  endsequence
  sequence s_mon_bad;
    monitor_request[0] [*2] ##0 (scan_done[0] && !scan_ok[0]);
  endsequence
  a_cmd_start: assert property (s_cmd_rise |=> command_busy && command_start)
    else $error("command did not start on request rise");
  a_cmd_done: assert property (s_cmd_ok |=> command_done && !command_busy)
    else $error("command completion not flagged");
  a_cmd_fail: assert property (s_cmd_bad |=> request_error && !command_done && !command_busy)
    else $error("command failure not flagged");
  a_done_cause: assert property ($rose(command_done) |-> $past(cmd_done && cmd_ok))
    else $error("done rose without a good completion");
  a_done_drop: assert property (command_done && !command_request |=> !command_done)
    else $error("done stayed after request drop");
  a_warn_clear: assert property (!warning_cause [*2] |-> !warning_flag)
    else $error("warning stayed without cause");
  a_ready_link: assert property (!fieldbus_link_ok |=> !station_ready)
    else $error("ready without fieldbus link");
  a_alarm_set: assert property (protect_trip |=> alarm_flag)
    else $error("alarm not set on trip");
  a_alarm_clear: assert property ($fell(alarm_clear) && !protect_trip |=> !alarm_flag)
    else $error("alarm not cleared on clear release");
  a_mon_start: assert property (!monitor_request[0] ##1 monitor_request[0] |=> monitor_active[0] && monitor_start[0])
    else $error("monitor did not start on request rise");
  a_mon_stop: assert property (!monitor_request[0] |=> !monitor_active[0])
    else $error("monitor active without request");
  a_mon_fail: assert property (s_mon_bad |=> !monitor_active[0] && request_error)
    else $error("monitor failure not flagged");
endmodule

bind mcs_status_flags mcs_status_flags_monitor u_mon (
  .ref_clk(ref_clk), .rst(rst), .monitor_request(monitor_request), .command_request(command_request),
  .alarm_clear(alarm_clear), .cmd_done(cmd_done), .cmd_ok(cmd_ok), .scan_done(scan_done), .scan_ok(scan_ok),
  .protect_trip(protect_trip), .warning_cause(warning_cause), .fieldbus_link_ok(fieldbus_link_ok),
  .command_busy(command_busy), .command_done(command_done), .request_error(request_error),
  .alarm_flag(alarm_flag), .warning_flag(warning_flag), .station_ready(station_ready),
  .monitor_active(monitor_active), .monitor_start(monitor_start), .command_start(command_start)
);

// ==== mcs_master_model.sv ====
// Fieldbus master model: request bits and monitor words
// Assumes its tasks are called just after a rising clock edge
`timescale 1ns/1ps
module mcs_master_model (
  input  wire logic                                  ref_clk,
  output logic [mcs_pkg::NUM_CH-1:0]                 monitor_request,
  output logic [mcs_pkg::NUM_CH*mcs_pkg::WORD_W-1:0] monitor_code_word,
  output logic [mcs_pkg::NUM_CH*mcs_pkg::WORD_W-1:0] monitor_target_word,
  output logic                                       command_request,
  output logic                                       alarm_clear
);
  import mcs_pkg::*;
  initial begin
    monitor_request = '0;
    monitor_code_word = '0;
    monitor_target_word = '0;
    command_request = 1'b0;
    alarm_clear = 1'b0;
  end
  // Words first, request one cycle later
  task automatic raise(input int k, input logic [WORD_W-1:0] code, input logic [WORD_W-1:0] tgt);
    monitor_code_word[WORD_W*k+:WORD_W] = code;
    monitor_target_word[WORD_W*k+:WORD_W] = tgt;
    @(posedge ref_clk);
    #1 monitor_request[k] = 1'b1;
  endtask
  task automatic drop(input int k);
    monitor_request[k] = 1'b0;
  endtask
  // Word change while requested, on purpose
  task automatic poke(input int k, input logic [WORD_W-1:0] code);
    monitor_code_word[WORD_W*k+:WORD_W] = code;
  endtask
  task automatic set_cmd(input logic v);
    command_request = v;
  endtask
  task automatic set_alarm_clear(input logic v);
    alarm_clear = v;
  endtask
endmodule

// ==== mcs_status_flags_tb.sv ====
// Self-checking bench for the status flag block
// Assumes the master model drives the master side, the bench the engine side
`timescale 1ns/1ps
module mcs_status_flags_tb;
  import mcs_pkg::*;
  logic ref_clk;
  logic rst;
  logic cmd_done, cmd_ok, link_err_valid;
  logic protect_trip, warning_cause, fieldbus_link_ok;
  logic [NUM_CH-1:0] scan_done, scan_ok;
  logic [NUM_CH*DATA_W-1:0] scan_data;
  logic [ERR_W-1:0] link_err_code;
  logic [NUM_CH-1:0] monitor_request, monitor_active, monitor_start;
  logic [NUM_CH*WORD_W-1:0] monitor_code_word, monitor_target_word, monitor_data_low, monitor_data_high;
  logic [NUM_CH*WORD_W-1:0] monitor_code_reg, monitor_target_reg;
  logic command_request, alarm_clear, command_busy, command_done, request_error, serial_link_ok;
  logic alarm_flag, warning_flag, station_ready, command_start;
  logic [ERR_W-1:0] comm_err_code_reg;
  int fail_count = 0;
  int checks = 0;

  mcs_master_model master (.*);
  mcs_status_flags dut (.*);

  always #5 ref_clk = ~ref_clk;

  // --------------------------------
  // Helpers
  // --------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input logic [95:0] got, input logic [95:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t %s got %h", $time, msg, got);
    end
  endtask
  task automatic cmd_end(input logic ok);
    cmd_ok = ok;
    cmd_done = 1'b1;
    tick(1);
    cmd_done = 1'b0;
  endtask
  task automatic scan(input int k, input logic ok, input logic [DATA_W-1:0] d);
    scan_ok[k] = ok;
    scan_data[DATA_W*k+:DATA_W] = d;
    scan_done[k] = 1'b1;
    tick(1);
    scan_done[k] = 1'b0;
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // --------------------------------
  // Scenarios
  // --------------------------------
  task automatic t_reset;
    tick(16);
    rst = 1'b0;
    tick(1);
    chk({command_busy, command_done, request_error, serial_link_ok, alarm_flag, warning_flag, station_ready,
         monitor_active, comm_err_code_reg}, 0, "flags after reset");
    chk(monitor_data_low | monitor_data_high, 0, "data after reset");
    $display("reset test done");
  endtask
  task automatic t_cmd_ok;
    master.set_cmd(1'b1);
    tick(1);
    chk({command_busy, command_start}, 2'b11, "command start");
    cmd_end(1'b1);
    chk({command_busy, command_done, request_error}, 3'b010, "command ok");
    tick(2);
    chk(command_done, 1, "done held");
    master.set_cmd(1'b0);
    tick(1);
    chk(command_done, 0, "done drop");
    $display("command ok test done");
  endtask
  task automatic t_cmd_fail;
    cmd_end(1'b1);
    chk(command_done, 0, "stray completion");
    master.set_cmd(1'b1);
    tick(1);
    chk(command_busy, 1, "second start");
    cmd_end(1'b0);
    chk({command_busy, command_done, request_error}, 3'b001, "command fail");
    master.set_cmd(1'b0);
    tick(1);
    chk(request_error, 0, "error drop");
    $display("command fail test done");
  endtask
  task automatic t_monitor;
    logic [WORD_W-1:0] tgt;
    logic [DATA_W-1:0] d;
    for (int k = 0; k < NUM_CH; k++) begin
      tgt = (k == 5) ? {8'h00, ADDR_SELF} : (k == 4) ? {8'h00, ADDR_LAST_SLAVE} : 16'(k);
      d = {16'h5a00 + 16'(k), 16'hc300 + 16'(k)};
      master.raise(k, 16'h0041 + 16'(k), tgt);
      tick(1);
      chk({monitor_active[k], monitor_start[k]}, 2'b11, "monitor start");
      chk({monitor_code_reg[WORD_W*k+:WORD_W], monitor_target_reg[WORD_W*k+:WORD_W]},
          {16'h0041 + 16'(k), tgt}, "capture");
      master.poke(k, 16'h00ff);
      scan(k, 1'b1, d);
      chk({monitor_data_high[WORD_W*k+:WORD_W], monitor_data_low[WORD_W*k+:WORD_W]}, d, "data words");
      chk(monitor_code_reg[WORD_W*k+:WORD_W], 16'h0041 + 16'(k), "code held");
      scan(k, 1'b1, ~d);
      master.drop(k);
      tick(1);
      scan(k, 1'b1, 32'h0);
      chk({monitor_active[k], monitor_data_high[WORD_W*k+:WORD_W], monitor_data_low[WORD_W*k+:WORD_W]},
          {1'b0, ~d}, "refresh then hold");
    end
    chk(serial_link_ok, 1, "link ok");
    $display("monitor test done");
  endtask
  task automatic t_mon_fail;
    master.raise(0, 16'h0041, 16'h0003);
    tick(1);
    scan(0, 1'b0, 32'h1234_5678);
    chk({monitor_active[0], request_error, monitor_data_high[15:0], monitor_data_low[15:0]}, {2'b01, 32'h0},
        "monitor fail");
    link_err_code = ERR_TIMEOUT;
    link_err_valid = 1'b1;
    tick(1);
    link_err_valid = 1'b0;
    tick(1);
    chk({serial_link_ok, comm_err_code_reg}, {1'b0, ERR_TIMEOUT}, "error code");
    master.drop(0);
    tick(1);
    chk(request_error, 0, "error drop");
    master.raise(0, 16'h0041, 16'h0003);
    tick(1);
    scan(0, 1'b1, 32'h0000_0001);
    tick(1);
    chk({monitor_active[0], serial_link_ok, comm_err_code_reg}, {2'b11, ERR_NONE}, "error code clear");
    master.drop(0);
    tick(1);
    $display("monitor fail test done");
  endtask
  task automatic t_flags;
    warning_cause = 1'b1;
    tick(2);
    chk(warning_flag, 1, "warning set");
    warning_cause = 1'b0;
    tick(2);
    chk(warning_flag, 0, "warning self clear");
    fieldbus_link_ok = 1'b1;
    tick(2);
    chk(station_ready, 1, "ready set");
    fieldbus_link_ok = 1'b0;
    tick(2);
    chk(station_ready, 0, "ready drop");
    protect_trip = 1'b1;
    tick(1);
    protect_trip = 1'b0;
    master.set_alarm_clear(1'b1);
    tick(2);
    chk(alarm_flag, 1, "alarm held on clear rise");
    master.set_alarm_clear(1'b0);
    tick(2);
    chk(alarm_flag, 0, "alarm clear");
    $display("flag test done");
  endtask

  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    cmd_done = 1'b0;
    cmd_ok = 1'b0;
    link_err_valid = 1'b0;
    protect_trip = 1'b0;
    warning_cause = 1'b0;
    fieldbus_link_ok = 1'b0;
    scan_done = '0;
    scan_ok = '0;
    scan_data = '0;
    link_err_code = ERR_NONE;
    t_reset();
    t_cmd_ok();
    t_cmd_fail();
    t_monitor();
    t_mon_fail();
    t_flags();
    print_verdict();
  end
  initial begin
    #100us;
    fail_count++;
    $display("ERROR t=%0t run limit reached", $time);
    print_verdict();
  end
endmodule
